/* File: design/run_state_defines.vh */
`ifndef RUN_STATE_DEFINES_VH
`define RUN_STATE_DEFINES_VH

// ****************************************
// Operating states
// ****************************************
`define ST_STOP   2'h0
`define ST_RUN    2'h1
`define ST_RESET  2'h2
`define ST_DEBUG  2'h3

// ****************************************
// Error classes and log layout
// ****************************************
`define ERR_CLASS_W    3
`define ERR_CODE_W     8
`define ERR_SYSTEM     3'h0
`define ERR_SETTING    3'h3
`define ERR_PROG       3'h4
`define ERR_SIGNAL     3'h5
`define LOG_DEPTH      16
`define LOG_HALF       8
`define LOG_IDX_W      4

// ****************************************
// Reset value and signal width
// ****************************************
`define RESET_STATE    `ST_RESET
`define SIG_W          8

`endif

/* File: design/cmd_pulse.v */
`timescale 1ns/1ps
`include "run_state_defines.vh"

// ****************************************
// Rising-edge detector for command inputs
// ****************************************
module cmd_pulse (
  // Clock and reset
  input  wire clk,
  input  wire nrst,
  // Level in, one-cycle pulse out
  input  wire level,
  output wire pulse
);

  reg level_q;

  // Remember the previous level so a held button gives one event.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level;
    end
  end

  assign pulse = level & ~level_q;

endmodule

/* File: design/error_log.v */
`timescale 1ns/1ps
`include "run_state_defines.vh"

// ****************************************
// Error memory: first eight and last eight
// ****************************************
module error_log #(
  parameter DEPTH = `LOG_DEPTH,
  parameter HALF  = `LOG_HALF
) (
  // Clock and reset
  input  wire                    clk,
  input  wire                    nrst,
  // New entry
  input  wire                    log_valid,
  input  wire [`ERR_CLASS_W-1:0] log_class,
  input  wire [`ERR_CODE_W-1:0]  log_code,
  // Clear everything except system errors
  input  wire                    clear,
  // Read port
  input  wire [`LOG_IDX_W-1:0]   rd_idx,
  output reg  [`ERR_CLASS_W-1:0] rd_class,
  output reg  [`ERR_CODE_W-1:0]  rd_code,
  output reg                     rd_valid,
  output reg  [`LOG_IDX_W:0]     count
);

  reg [`ERR_CLASS_W-1:0] cls_q [0:DEPTH-1];
  reg [`ERR_CODE_W-1:0]  code_q [0:DEPTH-1];
  reg [DEPTH-1:0]        vld_q;
  reg [`LOG_IDX_W-1:0]   first_free;
  reg [`LOG_IDX_W-2:0]   ring_q;
  integer                i;
  integer                j;

  // Slots 0..HALF-1 keep the first errors; the upper half is a ring of the latest.
  // A clear that meets a new entry keeps the entry, since losing an error is worse.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vld_q  <= {DEPTH{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        cls_q[i]  <= {`ERR_CLASS_W{1'b0}};
        code_q[i] <= {`ERR_CODE_W{1'b0}};
      end
    end else begin
      if (clear) begin
        for (i = 0; i < DEPTH; i = i + 1) begin
          if (cls_q[i] != `ERR_SYSTEM) begin
            vld_q[i] <= 1'b0;
          end
        end
      end
      if (log_valid) begin
        if (!(&vld_q[HALF-1:0])) begin
          cls_q[first_free]  <= log_class;
          code_q[first_free] <= log_code;
          vld_q[first_free]  <= 1'b1;
        end else begin
          cls_q[HALF + ring_q]  <= log_class;
          code_q[HALF + ring_q] <= log_code;
          vld_q[HALF + ring_q]  <= 1'b1;
        end
      end
    end
  end

  // Lowest free slot in the first half.
  // This loop has its own index so that no variable is written by two processes.
  always @* begin
    first_free = {`LOG_IDX_W{1'b0}};
    for (j = HALF - 1; j >= 0; j = j - 1) begin
      if (!vld_q[j]) begin
        first_free = j[`LOG_IDX_W-1:0];
      end
    end
  end

  // Ring pointer over the latest half.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ring_q <= {(`LOG_IDX_W-1){1'b0}};
    end else if (log_valid && (&vld_q[HALF-1:0])) begin
      ring_q <= ring_q + 1'b1;
    end else if (clear) begin
      ring_q <= {(`LOG_IDX_W-1){1'b0}};
    end
  end

  // Registered read port and entry count.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_class <= {`ERR_CLASS_W{1'b0}};
      rd_code  <= {`ERR_CODE_W{1'b0}};
      rd_valid <= 1'b0;
      count    <= {(`LOG_IDX_W+1){1'b0}};
    end else begin
      rd_class <= cls_q[rd_idx];
      rd_code  <= code_q[rd_idx];
      rd_valid <= vld_q[rd_idx];
      count    <= popcount(vld_q);
    end
  end

  function [`LOG_IDX_W:0] popcount;
    input [DEPTH-1:0] v;
    integer k;
    begin
      popcount = {(`LOG_IDX_W+1){1'b0}};
      for (k = 0; k < DEPTH; k = k + 1) begin
        popcount = popcount + {{`LOG_IDX_W{1'b0}}, v[k]};
      end
    end
  endfunction

endmodule

/* File: design/run_state_ctrl.v */
`timescale 1ns/1ps
`include "run_state_defines.vh"

module run_state_ctrl #(
  parameter OUT_W = 8,
  parameter AX_W  = 4
) (
  // Clock and reset
  input  wire                    clk,
  input  wire                    nrst,
  // Host commands (levels, one event per rising edge; host_link_ok gives one on its fall)
  input  wire                    host_stop,
  input  wire                    host_reset,
  input  wire                    host_cont,
  input  wire                    host_debug,
  input  wire                    host_link_ok,
  // Front panel selector
  input  wire                    panel_plus,
  input  wire                    panel_minus,
  // Program and system status
  input  wire                    prog_loaded,
  input  wire                    gear_mode,
  input  wire                    mode_change_req,
  input  wire [7:0]              mode_req,
  // Runtime errors
  input  wire                    err_valid,
  input  wire [`ERR_CLASS_W-1:0] err_class,
  input  wire [`ERR_CODE_W-1:0]  err_code,
  input  wire [`SIG_W-1:0]       err_signal,
  input  wire [AX_W-1:0]         sig_stop_axes,
  // Output image from program
  input  wire [OUT_W-1:0]        prog_outputs,
  // Error memory read
  input  wire [`LOG_IDX_W-1:0]   log_idx,
  output wire [`ERR_CLASS_W-1:0] log_class,
  output wire [`ERR_CODE_W-1:0]  log_code,
  output wire                    log_valid,
  output wire [`LOG_IDX_W:0]     log_count,
  // Resource words for the program
  input  wire                    read_resource_error_word,
  input  wire                    read_resource_signal_word,
  output reg  [`ERR_CODE_W-1:0]  res_error_q,
  output reg  [`SIG_W-1:0]       res_signal_q,
  // Control to the rest of the controller
  output reg  [1:0]              state_q,
  output reg                     prog_exec_q,
  output reg                     prog_rewind_q,
  output reg                     drive_en_q,
  output reg                     drive_init_q,
  output reg                     move_resume_q,
  output reg  [AX_W-1:0]         axis_hold_q,
  output reg                     pos_track_q,
  output reg                     if_alive_q,
  output reg                     bp_clear_q,
  output reg                     view_off_q,
  output reg  [OUT_W-1:0]        outputs_q,
  output reg                     outputs_en_q,
  output reg  [7:0]              mode_q,
  output reg                     dot_q,
  output reg                     sys_err_q
);

  // ****************************************
  // Command edges
  // ****************************************
  wire stop_p;
  wire reset_p;
  wire cont_p;
  wire debug_p;
  wire plus_p;
  wire minus_p;
  wire link_lost_p;

  cmd_pulse u_stop (.clk(clk), .nrst(nrst), .level(host_stop), .pulse(stop_p));
  cmd_pulse u_rst (.clk(clk), .nrst(nrst), .level(host_reset), .pulse(reset_p));
  cmd_pulse u_cont (.clk(clk), .nrst(nrst), .level(host_cont), .pulse(cont_p));
  cmd_pulse u_dbg (.clk(clk), .nrst(nrst), .level(host_debug), .pulse(debug_p));
  cmd_pulse u_plus (.clk(clk), .nrst(nrst), .level(panel_plus), .pulse(plus_p));
  cmd_pulse u_minus (.clk(clk), .nrst(nrst), .level(panel_minus), .pulse(minus_p));
  cmd_pulse u_link (.clk(clk), .nrst(nrst), .level(~host_link_ok), .pulse(link_lost_p));

  // ****************************************
  // Error classification
  // ****************************************
  wire err_sys   = err_valid && (err_class == `ERR_SYSTEM);
  wire err_stop  = err_valid && (err_class <= `ERR_SETTING);
  wire err_prog  = err_valid && (err_class == `ERR_PROG);
  wire err_sig   = err_valid && (err_class == `ERR_SIGNAL);
  wire do_reset  = reset_p | minus_p | plus_p;
  wire run_block = sys_err_q | err_sys | ~prog_loaded;

  error_log u_log (
    .clk       (clk),
    .nrst      (nrst),
    .log_valid (err_valid),
    .log_class (err_class),
    .log_code  (err_code),
    .clear     (do_reset),
    .rd_idx    (log_idx),
    .rd_class  (log_class),
    .rd_code   (log_code),
    .rd_valid  (log_valid),
    .count     (log_count)
  );

  // ****************************************
  // State transitions
  // ****************************************
  // Link loss wins over everything, and errors of class 0 to 3 in run over the other commands in the same cycle: a fault must never be masked.
  reg [1:0] state_d;
  always @* begin
    state_d = state_q;
    if (link_lost_p) begin
      state_d = `ST_RESET;
    end else if (err_stop && (state_q == `ST_RUN)) begin
      state_d = `ST_STOP;
    end else if (plus_p) begin
      if (state_q == `ST_DEBUG) begin
        state_d = run_block ? `ST_RESET : `ST_RUN;
      end else begin
        state_d = run_block ? `ST_RESET : `ST_RUN;
      end
    end else if (reset_p || minus_p) begin
      state_d = `ST_RESET;
    end else if (debug_p && (state_q != `ST_DEBUG)) begin
      state_d = `ST_DEBUG;
    end else if (state_q == `ST_DEBUG) begin
      state_d = `ST_DEBUG;
    end else if (stop_p && (state_q == `ST_RUN)) begin
      state_d = `ST_STOP;
    end else if (cont_p && (state_q == `ST_STOP) && !run_block) begin
      state_d = `ST_RUN;
    end else if ((state_q == `ST_RUN) && !prog_loaded) begin
      state_d = `ST_STOP;
    end
  end

  // ****************************************
  // State and status registers
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= `RESET_STATE;
      sys_err_q <= 1'b0;
      mode_q    <= 8'h01;
      dot_q     <= 1'b0;
    end else begin
      state_q <= state_d;
      // Only power cycling clears a system error.
      if (err_sys) begin
        sys_err_q <= 1'b1;
      end
      if (mode_change_req && (state_q == `ST_RESET)) begin
        mode_q <= mode_req;
      end
      dot_q <= (state_d == `ST_RUN);
    end
  end

  // ****************************************
  // Program, drive and output control
  // ****************************************
  // Outputs keep their image in stop and debug and are zeroed in reset; entering run loads the program's image again.
  wire entering_run = (state_d == `ST_RUN) && (state_q != `ST_RUN);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_exec_q   <= 1'b0;
      prog_rewind_q <= 1'b0;
      drive_en_q    <= 1'b0;
      drive_init_q  <= 1'b0;
      move_resume_q <= 1'b0;
      pos_track_q   <= 1'b0;
      if_alive_q    <= 1'b1;
      bp_clear_q    <= 1'b0;
      view_off_q    <= 1'b0;
      outputs_q     <= {OUT_W{1'b0}};
      outputs_en_q  <= 1'b0;
      axis_hold_q   <= {AX_W{1'b0}};
    end else begin
      prog_exec_q   <= (state_d == `ST_RUN) ||
                       ((state_d == `ST_DEBUG) && (state_q == `ST_DEBUG) && prog_exec_q);
      prog_rewind_q <= (state_d == `ST_RESET) || do_reset;
      drive_init_q  <= do_reset && !link_lost_p;
      bp_clear_q    <= do_reset && (state_q == `ST_DEBUG);
      view_off_q    <= do_reset && (state_q == `ST_DEBUG);
      move_resume_q <= entering_run && (state_q == `ST_STOP);
      if_alive_q    <= 1'b1;
      pos_track_q   <= gear_mode && (state_d == `ST_STOP);
      drive_en_q    <= (state_d == `ST_RUN) || (state_d == `ST_DEBUG);
      outputs_en_q  <= (state_d == `ST_RUN) || (state_d == `ST_DEBUG);
      if (state_d == `ST_RESET) begin
        outputs_q <= {OUT_W{1'b0}};
      end else if (state_d == `ST_RUN) begin
        outputs_q <= prog_outputs;
      end
      if (err_sig) begin
        axis_hold_q <= axis_hold_q | sig_stop_axes;
      end else if (do_reset) begin
        axis_hold_q <= {AX_W{1'b0}};
      end
    end
  end

  // ****************************************
  // Resource words
  // ****************************************
  // A new error wins over the program's read-to-clear in the same cycle.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_error_q  <= {`ERR_CODE_W{1'b0}};
      res_signal_q <= {`SIG_W{1'b0}};
    end else begin
      if (err_prog) begin
        res_error_q <= err_code;
      end else if (read_resource_error_word) begin
        res_error_q <= {`ERR_CODE_W{1'b0}};
      end
      if (err_sig) begin
        res_signal_q <= res_signal_q | err_signal;
      end else if (read_resource_signal_word) begin
        res_signal_q <= {`SIG_W{1'b0}};
      end
    end
  end

endmodule

/* File: sim/run_state_monitor.sv */
`timescale 1ns/1ps
`include "run_state_defines.vh"

// ****************************************
// Checker on the ports of the run-state controller
// ****************************************
module run_state_monitor #(
  parameter OUT_W = 8
) (
  // Clock and reset
  input wire                    clk,
  input wire                    nrst,
  // Commands and status
  input wire                    host_stop,
  input wire                    host_reset,
  input wire                    host_cont,
  input wire                    host_debug,
  input wire                    host_link_ok,
  input wire                    panel_plus,
  input wire                    panel_minus,
  input wire                    prog_loaded,
  input wire                    err_valid,
  input wire [`ERR_CLASS_W-1:0] err_class,
  // Controller outputs
  input wire [1:0]              state_q,
  input wire                    prog_exec_q,
  input wire                    drive_en_q,
  input wire                    drive_init_q,
  input wire                    move_resume_q,
  input wire                    if_alive_q,
  input wire [OUT_W-1:0]        outputs_q,
  input wire                    outputs_en_q,
  input wire [7:0]              mode_q,
  input wire                    dot_q,
  input wire                    sys_err_q
);
  // Link level is kept inverted so that every bit rises on its event.
  reg  [6:0] prev_q;
  wire [6:0] lvl_w  = {~host_link_ok, panel_minus, panel_plus, host_debug, host_cont,
                       host_reset, host_stop};
  wire [6:0] rise_w = lvl_w & ~prev_q;
  wire       in_run = state_q == `ST_RUN;
  wire       hard_w = err_valid && err_class <= 3'h3;

  // Previous levels, cleared like the design's own edge detectors.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) prev_q <= 7'h00;
    else prev_q <= lvl_w;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_run_active: assert property (in_run |-> prog_exec_q && outputs_en_q && dot_q)
    else $error("run state without program, outputs or dot");
  a_stop_quiet: assert property (state_q == `ST_STOP |-> !prog_exec_q && !drive_en_q
    && !outputs_en_q) else $error("stop state with activity");
  a_link_reset: assert property (rise_w[6] |=> state_q == `ST_RESET && !drive_en_q
    && outputs_q == 0) else $error("link loss did not reset");
  a_stop_enter: assert property (rise_w == 7'h01 && !err_valid && in_run
    |=> state_q == `ST_STOP && if_alive_q) else $error("stop from run failed");
  a_cmd_ignored: assert property (!err_valid && (rise_w == 7'h01 && !in_run
    || rise_w == 7'h04 && (state_q != `ST_STOP || sys_err_q || !prog_loaded))
    |=> $stable(state_q)) else $error("refused command changed state");
  a_cont_resume: assert property (rise_w == 7'h04 && !err_valid && state_q == `ST_STOP
    && !sys_err_q && prog_loaded |=> in_run && move_resume_q ##1 !move_resume_q)
    else $error("continue did not resume");
  a_err_stop: assert property (!rise_w[6] && hard_w && in_run |=> state_q == `ST_STOP)
    else $error("error class 0 to 3 did not stop");
  a_soft_err: assert property (err_valid && err_class >= 3'h4 && err_class <= 3'h5
    && rise_w == 7'h00 && in_run |=> in_run) else $error("error class 4 or 5 stopped");
  a_sys_block: assert property (sys_err_q |-> !in_run)
    else $error("run with system error");
  a_reset_cmd: assert property ((rise_w[1] || rise_w[5]) && rise_w[6:4] == 3'h0 && !err_valid
    |=> state_q == `ST_RESET && outputs_q == 0 && drive_init_q) else $error("reset failed");
  a_plus_run: assert property (rise_w[4] && !rise_w[6] && !err_valid && !sys_err_q
    && prog_loaded |=> in_run) else $error("plus did not run");
  a_debug_enter: assert property (rise_w == 7'h08 && !err_valid |=> state_q == `ST_DEBUG)
    else $error("debug not entered");
  a_debug_hold: assert property (state_q == `ST_DEBUG && rise_w[6:4] == 3'h0 && !rise_w[1]
    |=> state_q == `ST_DEBUG) else $error("debug left without reset");
  a_mode_gate: assert property (mode_q != $past(mode_q) |-> $past(state_q) == `ST_RESET)
    else $error("mode changed outside reset");

  c_run_entry: cover property (rise_w[2] && state_q == `ST_STOP ##1 in_run);
  c_debug: cover property (state_q == `ST_DEBUG);
  c_sys_err: cover property ($rose(sys_err_q));
endmodule

/* File: sim/cmd_source_model.sv */
`timescale 1ns/1ps

// ****************************************
// Host station and front-panel switch
// ****************************************
module cmd_source_model (
  // Clock and reset
  input  wire       clk,
  input  wire       nrst,
  // One event of the chosen kind per request
  input  wire       go,
  input  wire [2:0] sel,
  // Host and panel levels
  output wire       host_stop,
  output wire       host_reset,
  output wire       host_cont,
  output wire       host_debug,
  output wire       panel_plus,
  output wire       panel_minus,
  output wire       host_link_ok
);
  // A level stands one cycle, so a request gives exactly one edge; code 6 drops the link.
  reg [6:0] lvl_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) lvl_q <= 7'h00;
    else lvl_q <= go ? (7'h01 << sel) : 7'h00;
  end

  // Levels out; the link is up except during its one-cycle loss.
  assign {panel_minus, panel_plus, host_debug, host_cont, host_reset, host_stop} = lvl_q[5:0];
  assign host_link_ok = ~lvl_q[6];
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`include "run_state_defines.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch at %0t got %h expected %h", $time, (a), (b)); end end

// ****************************************
// Self-checking bench for the run-state controller
// ****************************************
module testbench;
  localparam [2:0] STP = 0, RST = 1, CNT = 2, DBG = 3, PLS = 4, MNS = 5, LNK = 6;
  logic       clk = 1'b0, nrst = 1'b0, go = 1'b0, prog_loaded = 1'b1, gear_mode = 1'b0;
  logic       mode_change_req = 1'b0, err_valid = 1'b0;
  logic       read_resource_error_word = 1'b0, read_resource_signal_word = 1'b0;
  logic [2:0] sel = 3'h0, err_class = 3'h0;
  logic [3:0] sig_stop_axes = 4'h5, log_idx = 4'h0;
  logic [7:0] mode_req = 8'h00, err_code = 8'h00, err_signal = 8'h01, prog_outputs = 8'ha5;
  wire        host_stop, host_reset, host_cont, host_debug, host_link_ok, panel_plus;
  wire        panel_minus, log_valid, prog_exec_q, prog_rewind_q, drive_en_q, drive_init_q;
  wire        move_resume_q, pos_track_q, if_alive_q, bp_clear_q, view_off_q, outputs_en_q;
  wire        dot_q, sys_err_q;
  wire [1:0]  state_q;
  wire [2:0]  log_class;
  wire [3:0]  axis_hold_q;
  wire [4:0]  log_count;
  wire [7:0]  log_code, res_error_q, res_signal_q, outputs_q, mode_q;
  int         n_mismatch = 0, checks = 0;

  // Clock at 25 MHz.
  always #20 clk = ~clk;

  cmd_source_model src_u (.clk(clk), .nrst(nrst), .go(go), .sel(sel), .host_stop(host_stop),
    .host_reset(host_reset), .host_cont(host_cont), .host_debug(host_debug),
    .panel_plus(panel_plus), .panel_minus(panel_minus), .host_link_ok(host_link_ok));

  run_state_ctrl dut_u (.clk(clk), .nrst(nrst), .host_stop(host_stop), .host_reset(host_reset),
    .host_cont(host_cont), .host_debug(host_debug), .host_link_ok(host_link_ok),
    .panel_plus(panel_plus), .panel_minus(panel_minus), .prog_loaded(prog_loaded),
    .gear_mode(gear_mode), .mode_change_req(mode_change_req), .mode_req(mode_req),
    .err_valid(err_valid), .err_class(err_class), .err_code(err_code),
    .err_signal(err_signal), .sig_stop_axes(sig_stop_axes), .prog_outputs(prog_outputs),
    .log_idx(log_idx), .log_class(log_class), .log_code(log_code), .log_valid(log_valid),
    .log_count(log_count), .read_resource_error_word(read_resource_error_word),
    .read_resource_signal_word(read_resource_signal_word), .res_error_q(res_error_q),
    .res_signal_q(res_signal_q), .state_q(state_q), .prog_exec_q(prog_exec_q),
    .prog_rewind_q(prog_rewind_q), .drive_en_q(drive_en_q), .drive_init_q(drive_init_q),
    .move_resume_q(move_resume_q), .axis_hold_q(axis_hold_q), .pos_track_q(pos_track_q),
    .if_alive_q(if_alive_q), .bp_clear_q(bp_clear_q), .view_off_q(view_off_q),
    .outputs_q(outputs_q), .outputs_en_q(outputs_en_q), .mode_q(mode_q), .dot_q(dot_q),
    .sys_err_q(sys_err_q));

  // Every task starts and ends just after a rising edge.
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One command; returns after the edge on which the controller acts on it.
  task cmd(input [2:0] k);
    go = 1'b1;
    sel = k;
    cyc(1);
    go = 1'b0;
    cyc(1);
  endtask

  // One runtime error; the code carries the class so log entries can be told apart.
  task err(input [2:0] c);
    err_valid = 1'b1;
    err_class = c;
    err_code = {5'h08, c};
    cyc(1);
    err_valid = 1'b0;
    cyc(1);
  endtask

  task set_mode(input [7:0] m);
    mode_change_req = 1'b1;
    mode_req = m;
    cyc(1);
    mode_change_req = 1'b0;
    cyc(1);
  endtask

  task t_power_up;
    `CHK({state_q, mode_q, if_alive_q}, {`ST_RESET, 8'h01, 1'b1})
    set_mode(8'h60);
    `CHK(mode_q, 8'h60)
    set_mode(8'h01);
  endtask

  task t_run_stop;
    cmd(PLS);
    `CHK({state_q, prog_exec_q, dot_q}, {`ST_RUN, 2'h3})
    set_mode(8'h70);
    `CHK(mode_q, 8'h01)
    cmd(STP);
    `CHK({state_q, prog_exec_q, drive_en_q, outputs_en_q, if_alive_q}, {`ST_STOP, 4'h1})
    cmd(STP);
    `CHK(state_q, `ST_STOP)
    cmd(CNT);
    `CHK({state_q, move_resume_q, outputs_en_q}, {`ST_RUN, 2'h3})
    `CHK(outputs_q, 8'ha5)
    cyc(1);
    `CHK(move_resume_q, 1'b0)
    prog_loaded = 1'b0;
    cyc(1);
    `CHK({state_q, outputs_en_q}, {`ST_STOP, 1'b0})
    cmd(CNT);
    `CHK(state_q, `ST_STOP)
    prog_loaded = 1'b1;
    cmd(CNT);
    `CHK(state_q, `ST_RUN)
  endtask

  task t_errors;
    for (int c = 1; c < 6; c++) begin
      err(c[2:0]);
      `CHK(state_q, (c < 4) ? `ST_STOP : `ST_RUN)
      if (c < 4) cmd(CNT);
      `CHK(state_q, `ST_RUN)
    end
    `CHK(axis_hold_q, 4'h5)
    `CHK({res_error_q, res_signal_q}, 16'h4401)
    read_resource_error_word = 1'b1;
    read_resource_signal_word = 1'b1;
    cyc(1);
    read_resource_error_word = 1'b0;
    read_resource_signal_word = 1'b0;
    `CHK({res_error_q, res_signal_q}, 16'h0000)
    `CHK(log_count, 5'h05)
    for (int i = 0; i < 14; i++) err(3'h4);
    cyc(2);
    `CHK({log_count, log_valid, log_class, log_code}, {5'h10, 1'b1, 3'h1, 8'h41})
  endtask

  task t_gear_reset;
    gear_mode = 1'b1;
    cmd(STP);
    `CHK(pos_track_q, 1'b1)
    gear_mode = 1'b0;
    cmd(RST);
    `CHK({state_q, drive_init_q, prog_rewind_q, outputs_q}, {`ST_RESET, 2'h3, 8'h00})
    cyc(2);
    `CHK(log_count, 5'h00)
  endtask

  task t_debug_link;
    cmd(PLS);
    cmd(DBG);
    cmd(STP);
    cmd(CNT);
    `CHK(state_q, `ST_DEBUG)
    cmd(MNS);
    `CHK({state_q, bp_clear_q, view_off_q}, {`ST_RESET, 2'h3})
    cmd(DBG);
    cmd(PLS);
    `CHK(state_q, `ST_RUN)
    cmd(LNK);
    `CHK({state_q, drive_en_q, outputs_q}, {`ST_RESET, 1'b0, 8'h00})
  endtask

  task t_sys_err;
    cmd(PLS);
    err(3'h0);
    `CHK({state_q, sys_err_q}, {`ST_STOP, 1'b1})
    cmd(CNT);
    `CHK(state_q, `ST_STOP)
    cmd(PLS);
    cyc(2);
    `CHK({state_q, log_count}, {`ST_RESET, 5'h01})
    // Only a reboot clears the system error and its log entry.
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(1);
    `CHK({state_q, sys_err_q, log_count}, {`ST_RESET, 6'h00})
  endtask

  task end_sim;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Main sequence after six cycles of reset.
  initial begin
    cyc(6);
    nrst = 1'b1;
    t_power_up;
    t_run_stop;
    t_errors;
    t_gear_reset;
    t_debug_link;
    t_sys_err;
    end_sim;
  end

  // The tests need about 110 cycles; this limit of 2000 cycles is generous.
  initial begin
    #80000;
    n_mismatch++;
    end_sim;
  end
endmodule

bind run_state_ctrl run_state_monitor #(.OUT_W(OUT_W)) mon_u (.clk(clk), .nrst(nrst),
  .host_stop(host_stop), .host_reset(host_reset), .host_cont(host_cont),
  .host_debug(host_debug), .host_link_ok(host_link_ok), .panel_plus(panel_plus),
  .panel_minus(panel_minus), .prog_loaded(prog_loaded), .err_valid(err_valid),
  .err_class(err_class), .state_q(state_q), .prog_exec_q(prog_exec_q),
  .drive_en_q(drive_en_q), .drive_init_q(drive_init_q), .move_resume_q(move_resume_q),
  .if_alive_q(if_alive_q), .outputs_q(outputs_q), .outputs_en_q(outputs_en_q),
  .mode_q(mode_q), .dot_q(dot_q), .sys_err_q(sys_err_q));
